/* File: rtl/tpc_pkg.sv */
// Purpose: Shared constants and types of the touch panel control block
// Assumes: 10 MHz system clock
// Notes:   Power mode codes follow the control byte bits
package tpc_pkg;

  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned READY_TIME_NS = 10_000;
  localparam int unsigned READY_CYCLES_I = READY_TIME_NS / (1_000_000_000 / CLK_HZ);
  localparam logic [6:0]  READY_CYCLES  = READY_CYCLES_I[6:0];

  // Control byte field positions
  localparam int unsigned BIT_MODE = 3;
  localparam int unsigned BIT_SER  = 2;
  localparam int unsigned BIT_PMHI = 1;
  localparam int unsigned BIT_PMLO = 0;

  // Rising edges counted from the start bit; conversion lengths counted in falling edges
  localparam logic [3:0] CNT_ZERO   = 4'h0;
  localparam logic [3:0] CNT_START  = 4'h1;
  localparam logic [3:0] CNT_ADDR   = 4'h3;
  localparam logic [3:0] CNT_ACQ    = 4'h4;
  localparam logic [3:0] CNT_BYTE   = 4'h8;
  localparam logic [3:0] LEN_12BIT  = 4'hc;
  localparam logic [3:0] LEN_8BIT   = 4'h8;

  localparam logic [1:0] PM_AUTO    = 2'h0;
  localparam logic [1:0] PM_REF_OFF = 2'h1;
  localparam logic [1:0] PM_ADC_OFF = 2'h2;
  localparam logic [1:0] PM_FULL    = 2'h3;
  localparam logic [1:0] PM_RESET   = PM_AUTO;

  localparam logic [2:0] ADDR_Y_POS = 3'h1;
  localparam logic [2:0] ADDR_X_POS = 3'h5;
  localparam logic [2:0] ADDR_RESET = 3'h0;
  localparam logic [6:0] SHIFT_RESET = 7'h00;

  typedef enum logic [1:0] {TPC_HUNT, TPC_CMD, TPC_CONV} tpc_state_t;

endpackage : tpc_pkg

/* File: rtl/tpc_bias_if.sv */
// Purpose: Carrier between sequencer and panel switch driver
// Assumes: Single clock domain
// Notes:   Switch states come back registered
`timescale 1ns/1ns
interface tpc_bias_if;
  logic       acq;
  logic       conv;
  logic       single_ended;
  logic [2:0] addr;
  logic       yp;
  logic       ym;
  logic       xp;
  logic       xm;
  logic       sense_x;
  logic       sense_y;

  modport ctrl (output acq, conv, single_ended, addr, input yp, ym, xp, xm, sense_x, sense_y);
  modport bias (input acq, conv, single_ended, addr, output yp, ym, xp, xm, sense_x, sense_y);
endinterface : tpc_bias_if

/* File: rtl/tpc_bias.sv */
// Purpose: Panel bias and sense switch driver
// Assumes: Phase flags from the sequencer on the same clock
// Notes:   Unknown channel addresses leave every switch open
`timescale 1ns/1ns
module tpc_bias (
  input wire logic  clk,
  input wire logic  arst_n,
  tpc_bias_if.bias  bi
);

  wire drive_on = bi.acq | (bi.conv & ~bi.single_ended);
  wire sense_on = drive_on;
  wire sel_y    = (bi.addr == tpc_pkg::ADDR_Y_POS);
  wire sel_x    = (bi.addr == tpc_pkg::ADDR_X_POS);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bi.yp      <= 1'b0;
      bi.ym      <= 1'b0;
      bi.xp      <= 1'b0;
      bi.xm      <= 1'b0;
      bi.sense_x <= 1'b0;
      bi.sense_y <= 1'b0;
    end else begin
      bi.yp      <= drive_on & sel_y;
      bi.ym      <= drive_on & sel_y;
      bi.xp      <= drive_on & sel_x;
      bi.xm      <= drive_on & sel_x;
      bi.sense_x <= sense_on & sel_y;
      bi.sense_y <= sense_on & sel_x;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  y_drive_a: assert property (bi.acq && sel_y |=> bi.yp && bi.ym && !bi.xp && !bi.xm)
    else $error("Vertical bias not applied");
  y_sense_a: assert property ((bi.acq || (bi.conv && !bi.single_ended)) && sel_y |=> bi.sense_x && !bi.sense_y)
    else $error("Vertical sense path wrong");
  x_drive_a: assert property (bi.acq && sel_x |=> bi.xp && bi.xm && bi.sense_y && !bi.yp)
    else $error("Horizontal bias not applied");
  se_open_a: assert property (bi.conv && bi.single_ended
                              |=> !(bi.yp || bi.ym || bi.xp || bi.xm || bi.sense_x || bi.sense_y))
    else $error("Switches closed in single ended conversion");
  dfr_hold_a: assert property (bi.conv && !bi.single_ended && sel_y |=> bi.yp && bi.ym)
    else $error("Switches open in differential conversion");
  idle_open_a: assert property (!bi.acq && !bi.conv |=> !(bi.yp || bi.xp || bi.sense_x || bi.sense_y))
    else $error("Switch closed while idle");

endmodule : tpc_bias

/* File: rtl/tpc_ctrl.sv */
// Purpose: Serial control, power sequencing and panel bias of a touch converter
// Assumes: Serial pins and pen detect are asynchronous to MCLK
// Notes:   Serial shift clock is sampled; one edge per MCLK at most
`timescale 1ns/1ns

// Overview of operation
// - Vertical measurement drives both vertical layer ends, supply and ground.
// - Vertical measurement senses through the horizontal plus input only.
// - Accepted request closes selected bias switches at acquisition start.
// - Single-ended: all panel switches open through the whole conversion.
// - Differential: switches stay closed from acquisition start to conversion end.
// - After reset, with select low, first sampled one is the start bit.
// - Serial output shows only zeros until a conversion takes place.
// - Selected power mode applies after conversion end, held until next byte.
// - Serial port stays alive in low power; new byte restores converter power, and reference power unless mode low-only is pending.
// - Reset sets both power mode bits to zero.
// - Converter is ready 101 MCLK cycles, 10.1 microseconds, after leaving shutdown.
// - Both mode bits set keeps reference always powered, converter powered while select is low.
// - Mode zero powers down at conversion end or select rise.
// - Mode high-only powers the converter down likewise, reference stays on; next command restores power.
// - Mode low-only switches reference off, converter stays powered while select is low.
// - Select rising powers down at once and aborts any conversion.
// - Select rising leaves the reference alone; only mode bits and busy control it.
// - Byte bit two selects input configuration, bits one and zero power mode.
// - Mode high-only keeps converter off and reference on between conversions.
// - Pen interrupt enabled only in power mode zero.
// - With select high, serial inputs ignored and serial output released.
module tpc_ctrl (
  input  wire logic MCLK,
  input  wire logic ARST_N,
  input  wire logic CS_N,
  input  wire logic SERIAL_DATA_IN,
  input  wire logic SERIAL_SHIFT_CLOCK,
  input  wire logic PEN_TOUCH,
  input  wire logic CONV_BIT,
  output logic      SERIAL_DATA_OUT,
  output logic      SERIAL_DATA_OUT_OE,
  output logic      BUSY,
  output logic      BUSY_OE,
  output logic      Y_PLUS_DRV,
  output logic      Y_MINUS_DRV,
  output logic      X_PLUS_DRV,
  output logic      X_MINUS_DRV,
  output logic      SENSE_X_PLUS,
  output logic      SENSE_Y_PLUS,
  output logic      ADC_PWR,
  output logic      REF_PWR,
  output logic      ADC_READY,
  output logic      RES_8BIT,
  output logic      PEN_TOUCH_IRQ_N
);

  localparam int unsigned NSYNC = 4;

  tpc_bias_if bif ();

  // Two-stage synchronisers for pins
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  localparam logic [NSYNC-1:0] SYNC_RESET = 4'h1;

  assign pin_raw = {PEN_TOUCH, SERIAL_SHIFT_CLOCK, SERIAL_DATA_IN, CS_N};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
          sync1_reg[gi] <= SYNC_RESET[gi];
          sync2_reg[gi] <= SYNC_RESET[gi];
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  wire cs_s   = sync2_reg[0];
  wire din_s  = sync2_reg[1];
  wire sclk_s = sync2_reg[2];
  wire pen_s  = sync2_reg[3];

  logic cs_d_reg;
  logic sclk_d_reg;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cs_d_reg   <= 1'b1;
      sclk_d_reg <= 1'b0;
    end else begin
      cs_d_reg   <= cs_s;
      sclk_d_reg <= sclk_s;
    end
  end

  wire cs_rise   = cs_s & ~cs_d_reg;
  wire cs_fall   = ~cs_s & cs_d_reg;
  wire sclk_rise = sclk_s & ~sclk_d_reg & ~cs_s;
  wire sclk_fall = ~sclk_s & sclk_d_reg & ~cs_s;

  // Sequencer
  tpc_pkg::tpc_state_t state_reg;
  tpc_pkg::tpc_state_t state_next;
  logic [3:0]          bit_cnt_reg;
  logic [3:0]          conv_cnt_reg;
  logic [6:0]          shift_reg;
  logic [2:0]          addr_reg;
  logic                ser_reg;
  logic                mode8_reg;
  logic [1:0]          pm_pend_reg;
  logic [1:0]          pm_reg;
  logic                hw_pd_reg;

  wire       start_seen = (state_reg == tpc_pkg::TPC_HUNT) & sclk_rise & din_s;
  wire       byte_done  = (state_reg == tpc_pkg::TPC_CMD) & sclk_fall & (bit_cnt_reg == tpc_pkg::CNT_BYTE);
  wire [3:0] conv_len   = mode8_reg ? tpc_pkg::LEN_8BIT : tpc_pkg::LEN_12BIT;
  wire       conv_done  = (state_reg == tpc_pkg::TPC_CONV) & sclk_fall & (conv_cnt_reg == conv_len - 4'h1);
  wire       acq        = (state_reg == tpc_pkg::TPC_CMD) & (bit_cnt_reg >= tpc_pkg::CNT_ACQ);
  wire       conv       = (state_reg == tpc_pkg::TPC_CONV);
  wire       busy_any   = acq | conv;
  wire       bit_shift  = (state_reg == tpc_pkg::TPC_CMD) & sclk_rise & (bit_cnt_reg < tpc_pkg::CNT_BYTE);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      tpc_pkg::TPC_HUNT: if (start_seen) state_next = tpc_pkg::TPC_CMD;
      tpc_pkg::TPC_CMD:  if (byte_done) state_next = tpc_pkg::TPC_CONV;
      tpc_pkg::TPC_CONV: if (conv_done) state_next = tpc_pkg::TPC_HUNT;
    endcase
    if (cs_rise) begin
      state_next = tpc_pkg::TPC_HUNT;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= tpc_pkg::TPC_HUNT;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_cnt_reg <= tpc_pkg::CNT_ZERO;
      shift_reg   <= tpc_pkg::SHIFT_RESET;
    end else if (start_seen) begin
      bit_cnt_reg <= tpc_pkg::CNT_START;
    end else if (bit_shift) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      shift_reg   <= {shift_reg[5:0], din_s};
    end
  end

  // Address is caught as its last bit arrives, before acquisition
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      addr_reg <= tpc_pkg::ADDR_RESET;
    end else if (bit_shift && bit_cnt_reg == tpc_pkg::CNT_ADDR) begin
      addr_reg <= {shift_reg[1:0], din_s};
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ser_reg     <= 1'b0;
      mode8_reg   <= 1'b0;
      pm_pend_reg <= tpc_pkg::PM_RESET;
    end else if (byte_done) begin
      ser_reg     <= shift_reg[tpc_pkg::BIT_SER];
      mode8_reg   <= shift_reg[tpc_pkg::BIT_MODE];
      pm_pend_reg <= {shift_reg[tpc_pkg::BIT_PMHI], shift_reg[tpc_pkg::BIT_PMLO]};
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      conv_cnt_reg <= tpc_pkg::CNT_ZERO;
    end else if (byte_done) begin
      conv_cnt_reg <= tpc_pkg::CNT_ZERO;
    end else if (conv && sclk_fall) begin
      conv_cnt_reg <= conv_cnt_reg + 4'h1;
    end
  end

  // Power mode takes over at conversion end or select release
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pm_reg <= tpc_pkg::PM_RESET;
    end else if (conv_done || cs_rise) begin
      pm_reg <= pm_pend_reg;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hw_pd_reg <= 1'b0;
    end else if (cs_rise) begin
      hw_pd_reg <= 1'b1;
    end else if (cs_fall) begin
      hw_pd_reg <= 1'b0;
    end
  end

  // Converter runs in any conversion, otherwise per low mode bit while select is low
  wire adc_pwr_next = busy_any | (pm_reg[0] & ~hw_pd_reg);
  // Reference follows the high mode bit, and runs while busy unless mode low-only is pending; select has no say
  wire ref_pwr_next = pm_reg[1] | (busy_any & (pm_pend_reg != tpc_pkg::PM_REF_OFF));
  wire irq_en       = (pm_reg == tpc_pkg::PM_AUTO);

  logic       adc_pwr_reg;
  logic       ref_pwr_reg;
  logic       pen_irq_n_reg;
  logic [6:0] ready_cnt_reg;
  logic       ready_reg;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      adc_pwr_reg   <= 1'b0;
      ref_pwr_reg   <= 1'b0;
      pen_irq_n_reg <= 1'b1;
    end else begin
      adc_pwr_reg   <= adc_pwr_next;
      ref_pwr_reg   <= ref_pwr_next;
      pen_irq_n_reg <= ~(irq_en & pen_s & ~busy_any);
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ready_cnt_reg <= 7'h00;
      ready_reg     <= 1'b0;
    end else if (!adc_pwr_reg) begin
      ready_cnt_reg <= 7'h00;
      ready_reg     <= 1'b0;
    end else if (ready_cnt_reg != tpc_pkg::READY_CYCLES) begin
      ready_cnt_reg <= ready_cnt_reg + 7'h01;
    end else begin
      ready_reg     <= 1'b1;
    end
  end

  // Serial output and busy flag
  logic dout_reg;
  logic dout_oe_reg;
  logic busy_reg;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dout_reg <= 1'b0;
    end else if (cs_rise) begin
      dout_reg <= 1'b0;
    end else if (sclk_fall) begin
      dout_reg <= conv & ~byte_done & CONV_BIT;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      busy_reg <= 1'b0;
    end else if (cs_rise) begin
      busy_reg <= 1'b0;
    end else if (sclk_fall) begin
      busy_reg <= byte_done;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dout_oe_reg <= 1'b0;
    end else begin
      dout_oe_reg <= ~cs_s;
    end
  end

  // Panel switch driver
  assign bif.acq          = acq;
  assign bif.conv         = conv;
  assign bif.single_ended = ser_reg;
  assign bif.addr         = addr_reg;

  tpc_bias u_bias (
    .clk    (MCLK),
    .arst_n (ARST_N),
    .bi     (bif.bias)
  );

  assign SERIAL_DATA_OUT    = dout_reg;
  assign SERIAL_DATA_OUT_OE = dout_oe_reg;
  assign BUSY               = busy_reg;
  assign BUSY_OE            = dout_oe_reg;
  assign Y_PLUS_DRV         = bif.yp;
  assign Y_MINUS_DRV        = bif.ym;
  assign X_PLUS_DRV         = bif.xp;
  assign X_MINUS_DRV        = bif.xm;
  assign SENSE_X_PLUS       = bif.sense_x;
  assign SENSE_Y_PLUS       = bif.sense_y;
  assign ADC_PWR            = adc_pwr_reg;
  assign REF_PWR            = ref_pwr_reg;
  assign ADC_READY          = ready_reg;
  assign RES_8BIT           = mode8_reg;
  assign PEN_TOUCH_IRQ_N    = pen_irq_n_reg;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  sequence s_abort;
    cs_rise ##1 (state_reg == tpc_pkg::TPC_HUNT && hw_pd_reg);
  endsequence

  sequence s_done_auto;
    conv_done && pm_pend_reg == tpc_pkg::PM_AUTO ##1 pm_reg == tpc_pkg::PM_AUTO;
  endsequence

  start_hunt_a: assert property (start_seen && !cs_rise |=> state_reg == tpc_pkg::TPC_CMD)
    else $error("Start bit not taken");
  zero_out_a: assert property (state_reg == tpc_pkg::TPC_HUNT && sclk_fall |=> !dout_reg)
    else $error("Serial output not zero outside conversion");
  mode_defer_a: assert property (conv && !conv_done && !cs_rise |=> $stable(pm_reg))
    else $error("Power mode changed during conversion");
  mode_apply_a: assert property (conv_done |=> pm_reg == $past(pm_pend_reg))
    else $error("Power mode not applied at conversion end");
  full_power_a: assert property (busy_any |=> adc_pwr_reg)
    else $error("Converter not powered in conversion");
  ref_hold_a: assert property (cs_rise && pm_reg[1] && pm_pend_reg[1] |=> ref_pwr_reg [*2])
    else $error("Reference dropped on select rise");
  abort_pd_a: assert property (s_abort |=> !adc_pwr_reg)
    else $error("Select rise did not power down");
  auto_off_a: assert property (s_done_auto |=> !adc_pwr_reg)
    else $error("Mode zero did not power down");
  irq_gate_a: assert property (pm_reg != tpc_pkg::PM_AUTO |=> PEN_TOUCH_IRQ_N)
    else $error("Pen interrupt outside mode zero");
  ignore_cs_a: assert property (cs_s |=> !dout_oe_reg && state_reg == tpc_pkg::TPC_HUNT)
    else $error("Serial port active with select high");
  ready_time_a: assert property (ready_cnt_reg == tpc_pkg::READY_CYCLES && adc_pwr_reg |=> ready_reg)
    else $error("Ready not reached in time");

endmodule : tpc_ctrl

/* File: test/tpc_host.sv */
// Purpose: Host stand-in driving the serial pins of the touch panel block
// Assumes: Shift clock of 8 MCLK, 4 low and 4 high, fifth frame bit low phase stretched; idle low outside frames
// Notes:   Also plays the converter core decision bit
`timescale 1ns/1ns
module tpc_host (
  input  wire logic       mclk,
  input  wire logic       dout,
  input  wire logic       busy,
  input  wire logic [6:0] sw,
  output logic            cs_n,
  output logic            din,
  output logic            sclk,
  output logic            conv
);
  logic [15:0] bits;
  logic [15:0] busy_bits;
  logic [6:0]  snap;
  logic [6:0]  sw_acq;
  logic [6:0]  sw_conv;
  logic        lead_or;
  logic        first;

  initial begin
    cs_n = 1'b1;
    din = 1'b0;
    sclk = 1'b0;
    conv = 1'b0;
    first = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  // One shift clock period; samples just before the rising edge
  task automatic pulse(input logic d, input int low, input int idx);
    din = d;
    tick(low);
    snap = sw;
    if (idx < 0) lead_or = lead_or | dout;
    else if (idx < 16) begin
      bits[idx] = dout;
      busy_bits[idx] = busy;
    end
    sclk = 1'b1;
    tick(4);
    sclk = 1'b0;
  endtask : pulse

  // Released data line shows the inverse of its last value
  task automatic release_cs;
    cs_n = 1'b1;
    din = ~din;
  endtask : release_cs

  task automatic noise;
    repeat (3) pulse(1'b1, 4, 16);
  endtask : noise

  task automatic frame(input logic [7:0] cb, input logic [15:0] cv, input int lead, input int abort,
                       input int stretch);
    if (first) tick(100);
    first = 1'b0;
    bits = 16'h0000;
    busy_bits = 16'h0000;
    lead_or = 1'b0;
    cs_n = 1'b0;
    tick(4);
    for (int i = 0; i < lead; i++) pulse(1'b0, 4, -1);
    for (int i = 0; i < 24; i++) begin
      if (i == abort) begin
        release_cs();
        return;
      end
      // Decision bit stands while the previous fall is seen
      if (i >= 9) conv = cv[i - 9];
      pulse((i < 8) ? cb[7 - i] : 1'b0, (i == 4) ? 4 + stretch : 4, (i >= 8) ? i - 8 : 16);
      if (i == 4) sw_acq = snap;
      if (i == 11) sw_conv = snap;
    end
    tick(4);
  endtask : frame
endmodule : tpc_host

/* File: test/tb.sv */
// Purpose: Self-checking bench of the touch panel control block
// Assumes: 10 MHz MCLK, host shift clock of 800 ns apart from the stretched fifth frame bit
// Notes:   Seeded random frames among fixed corner cases
`timescale 1ns/1ns
module tb;
  logic mclk;
  logic arst_n;
  logic pen;
  logic cs_n, din, sclk, conv;
  logic dout, dout_oe, busy, busy_oe, adc, ref_on, ready, res8, irq_n;
  logic yp, ym, xp, xm, sx, sy;
  int   errors = 0;
  int   compares = 0;
  int   cycles = 0;
  int   seed = 32'h1246;

  tpc_ctrl dut (
    .MCLK(mclk), .ARST_N(arst_n), .CS_N(cs_n), .SERIAL_DATA_IN(din), .SERIAL_SHIFT_CLOCK(sclk),
    .PEN_TOUCH(pen), .CONV_BIT(conv), .SERIAL_DATA_OUT(dout), .SERIAL_DATA_OUT_OE(dout_oe), .BUSY(busy),
    .BUSY_OE(busy_oe), .Y_PLUS_DRV(yp), .Y_MINUS_DRV(ym), .X_PLUS_DRV(xp), .X_MINUS_DRV(xm),
    .SENSE_X_PLUS(sx), .SENSE_Y_PLUS(sy), .ADC_PWR(adc), .REF_PWR(ref_on), .ADC_READY(ready),
    .RES_8BIT(res8), .PEN_TOUCH_IRQ_N(irq_n)
  );

  tpc_host host (
    .mclk(mclk), .dout(dout), .busy(busy), .sw({adc, yp, ym, xp, xm, sx, sy}),
    .cs_n(cs_n), .din(din), .sclk(sclk), .conv(conv)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  // Switch set {y+, y-, x+, x-, sense x, sense y} for a channel
  function automatic logic [5:0] exp_sw(input logic [2:0] a);
    if (a == tpc_pkg::ADDR_Y_POS) return 6'h32;
    if (a == tpc_pkg::ADDR_X_POS) return 6'h0d;
    return 6'h00;
  endfunction : exp_sw

  task automatic run(input logic [7:0] cb, input int lead, input int abort, input logic rel);
    logic [15:0] cv;
    logic [15:0] ev;
    int          nb;
    cv = 16'($random(seed));
    nb = cb[3] ? 8 : 12;
    ev = 16'h0000;
    for (int k = 1; k < 16; k++) ev[k] = (k <= nb) ? cv[k - 1] : 1'b0;
    host.frame(cb, cv, lead, abort, int'({$random(seed)} % 40));
    repeat (6) @(negedge mclk);
    if (abort < 24) begin
      check("abort", {busy, dout_oe, yp, ym, xp, xm, sx, sy, adc}, 9'h000);
      if (abort >= 8) check("abort ref", ref_on, cb[1]);
    end else begin
      check("switch acq", host.sw_acq, {1'b1, exp_sw(cb[6:4])});
      check("switch conv", host.sw_conv, {1'b1, cb[2] ? 6'h00 : exp_sw(cb[6:4])});
      check("busy", host.busy_bits[1:0], 2'h1);
      check("result", host.bits[15:1], ev[15:1]);
      check("res8", res8, cb[3]);
      check("idle", {yp, ym, xp, xm, sx, sy}, 6'h00);
      check("power", {adc, ref_on, ready}, {cb[0], cb[1], cb[0]});
      check("pen irq", irq_n, {~(pen & (cb[1:0] == tpc_pkg::PM_AUTO))});
      if (rel) begin
        host.release_cs();
        repeat (6) @(negedge mclk);
        check("released", {dout_oe, busy_oe, busy, adc, ref_on}, {4'h0, cb[1]});
      end
    end
    $display("frame %h done", cb);
  endtask : run

  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      conclude();
    end
  end

  initial begin
    arst_n = 1'b0;
    pen = 1'b1;
    repeat (10) @(negedge mclk);
    check("reset out", {dout_oe, busy_oe, busy, yp, ym, xp, xm, sx, sy, adc, ref_on, ready, irq_n}, 13'h0001);
    arst_n = 1'b1;
    repeat (8) @(negedge mclk);
    check("reset mode", {ref_on, adc, irq_n}, 3'h0);
    host.noise();
    check("noise", {busy, dout_oe, yp, ym, sx}, 5'h00);
    $display("reset test done");
    run(8'h93, 3, 24, 1'b0);
    check("lead zeros", host.lead_or, 1'b0);
    run(8'h90, 0, 24, 1'b1);
    run(8'hd7, 1, 24, 1'b0);
    run(8'hd4, 0, 24, 1'b1);
    run(8'h9e, 0, 14, 1'b0);
    run(8'hde, 0, 6, 1'b0);
    for (int m = 0; m < 4; m++) run({6'h26, 2'(m)}, 0, 24, 1'b1);
    for (int n = 0; n < 16; n++) begin
      pen = 1'($random(seed));
      run({1'b1, 7'($random(seed))}, int'({$random(seed)} % 3), 24, 1'($random(seed)));
    end
    conclude();
  end
endmodule : tb
